// *** pkg/host_port_consts.vh ***
// Constants for the acquisition board host control port
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

`define LOC_PRIMARY     1'b0
`define LOC_SECONDARY   1'b1
`define CTRL_RESET      16'h7FF0
`define BIT_CAPTURE     0
`define BIT_ARM         1
`define BIT_GAIN2       2
`define BIT_VEDGE       3
`define BIT_SAMPLE_N    4
`define BIT_MEMWR_N     5
`define BIT_ADDRLD_N    6
`define BIT_POSTLD_N    7
`define BIT_VTRIG_N     8
`define BIT_RDCLK_N     9
`define BIT_MEMRD_N     10
`define BIT_TRIGRD_N    11
`define BIT_RATELD_N    12
`define BIT_SWPREL_N    13
`define BIT_LEVELD_N    14
`define BIT_MINDET      15

`endif

// *** hdl/fast_adc_host_control_port.v ***
// Host control port and control word register of the acquisition board
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.vh"

// Operation
// (RULE_01) Link is 8-bit two-way bus, one select line, high and low byte strobes.
// (RULE_02) Select low addresses the control word, high addresses the data location.
// (RULE_03) Words move as two bytes, high byte first then low byte.
// (RULE_04) Control word is 16 bits written by the host in two bytes.
// (RULE_05) Data location takes byte and word reads and writes.
// (RULE_06) Bus direction comes only from the control word, no read/write pin.
// (RULE_07) Host sets direction bits before data accesses to avoid contention.
// (RULE_08) Bit 0 runs clocks and capture; memory readable only when it is 0.
// (RULE_09) Bit 1 arms the trigger from sweep line or video trigger.
// (RULE_10) Bit 2 turns the times-two expansion amplifier on.
// (RULE_11) Bit 3 picks video edge; bit 8 low enables video trigger.
// (RULE_12) Bit 4 low selects sample detection, high allows peak or pit.
// (RULE_13) Bit 5 low enables memory writes, changed together with bit 0.
// (RULE_14) Bits 6 and 7 low permit address and post counter loads.
// (RULE_15) Bit 9 low clocks counter loads and post-increments after reads.
// (RULE_16) Bit 10 low lets the host read sample memory.
// (RULE_17) Bit 11 low lets the host read the trigger address latch.
// (RULE_18) Bit 12 low lets host writes load the sample rate latch.
// (RULE_19) Bit 13 low releases the sweep strobe.
// (RULE_20) Bit 14 low lets host writes load the video trigger level.
// (RULE_21) With bit 4 high, bit 15 picks pit (1) or peak (0).
// (RULE_22) Counter load: enable load and read clock, then write word.
// (RULE_23) Reset leaves control word inactive: low bits 0, active-low bits 1.
module fast_adc_host_control_port (
  input  wire        clk_sys_i,                   // System clock 50 MHz
  input  wire        nrst_i,                      // Async reset, active low
  input  wire        ce_i,                        // Clock enable
  input  wire        location_select_line_i,      // Location select pin
  input  wire        high_byte_strobe_i,          // High byte strobe pin
  input  wire        low_byte_strobe_i,           // Low byte strobe pin
  input  wire [7:0]  data_i,                      // Bus data in
  output reg  [7:0]  data_o,                      // Bus data out
  output reg         data_oe_o,                   // Bus drive enable
  input  wire [15:0] mem_word_i,                  // Sample memory read word
  input  wire [15:0] trig_addr_i,                 // Trigger address latch word
  output reg  [15:0] sec_wdata_o,                 // Data location write word
  output reg         sec_wr_o,                    // Data location write pulse
  output reg         sec_rd_o,                    // Data location read done pulse
  output reg         addr_counter_load_o,         // Load address counter pulse
  output reg         post_count_load_o,           // Load post counter pulse
  output reg         rate_latch_load_o,           // Load rate latch pulse
  output reg         trig_level_load_o,           // Load trigger level pulse
  output reg         addr_incr_o,                 // Address post-increment pulse
  output reg         capture_run_o,               // Clocks running, capturing
  output reg         trig_arm_o,                  // Trigger armed
  output reg         double_gain_select_o,        // Times-two amplifier on
  output reg         video_trigger_edge_select_o, // 1 negative video edge
  output reg         video_trigger_active_o,      // Video trigger enabled
  output reg         sample_detect_o,             // Sample detection selected
  output reg         min_detect_select_o,         // Pit detection selected
  output reg         peak_detect_o,               // Peak detection selected
  output reg         memory_write_enable_o,       // Memory write enabled
  output reg         sweep_strobe_release_o       // Sweep strobe released
);

  // Synchroniser depth; the last stage only feeds the edge detectors
  localparam SYNC_LEN = 3;

  reg  [SYNC_LEN-1:0] sel_s_r;
  reg  [SYNC_LEN-1:0] hi_s_r;
  reg  [SYNC_LEN-1:0] lo_s_r;
  reg  [7:0]          data_s1_r;
  reg  [7:0]          data_s2_r;
  reg  [15:0]         ctrl_r;
  reg  [15:0]         ctrl_nxt;
  reg  [7:0]          hi_byte_r;
  reg                 hi_seen_r;
  reg  [15:0]         rd_word_r;
  reg  [15:0]         rd_word_nxt;

  // Joins a stored high byte with the low byte that ends a transfer
  function [15:0] merge_word;
    input       hi_valid;
    input [7:0] hi_byte;
    input [7:0] hi_fallback;
    input [7:0] lo_byte;
    begin
      if (hi_valid) begin
        merge_word = {hi_byte, lo_byte};
      end else begin
        merge_word = {hi_fallback, lo_byte};
      end
    end
  endfunction

  // Memory word has priority over the trigger latch
  function [15:0] read_source;
    input        mem_sel;
    input [15:0] mem_word;
    input [15:0] trig_word;
    begin
      if (mem_sel) begin
        read_source = mem_word;
      end else begin
        read_source = trig_word;
      end
    end
  endfunction

  wire       sel_now      = sel_s_r[1];
  wire       hi_level     = hi_s_r[1];
  wire       lo_level     = lo_s_r[1];
  wire       hi_rise      = hi_s_r[1] & ~hi_s_r[2];
  wire       lo_rise      = lo_s_r[1] & ~lo_s_r[2];
  wire       hi_fall      = ~hi_s_r[1] & hi_s_r[2];
  wire       lo_fall      = ~lo_s_r[1] & lo_s_r[2];
  wire       strobe_on    = hi_level | lo_level;
  wire       at_primary   = (sel_now == `LOC_PRIMARY);
  wire       at_secondary = (sel_now == `LOC_SECONDARY);
  wire [7:0] bus_byte     = data_s2_r;

  // (RULE_06) direction from word
  wire       rd_mem       = ~ctrl_r[`BIT_MEMRD_N] & ~ctrl_r[`BIT_CAPTURE];
  wire       rd_trig      = ~ctrl_r[`BIT_TRIGRD_N];
  wire       rd_en        = rd_mem | rd_trig;
  wire       rd_clk       = ~ctrl_r[`BIT_RDCLK_N];

  // (RULE_04) two-byte control write
  always @* begin
    ctrl_nxt = ctrl_r;
    if (at_primary && lo_fall) begin
      ctrl_nxt = merge_word(hi_seen_r, hi_byte_r, ctrl_r[15:8], bus_byte);
    end
  end

  // Word offered to the host on a read
  always @* begin
    rd_word_nxt = read_source(rd_mem, mem_word_i, trig_addr_i);
  end

  // (RULE_01) pin synchronisers
  // Data bus passes the same two stages as the strobes
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_s_r   <= {SYNC_LEN{1'b0}};
      hi_s_r    <= {SYNC_LEN{1'b0}};
      lo_s_r    <= {SYNC_LEN{1'b0}};
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
    end else if (ce_i) begin
      sel_s_r   <= {sel_s_r[SYNC_LEN-2:0], location_select_line_i};
      hi_s_r    <= {hi_s_r[SYNC_LEN-2:0], high_byte_strobe_i};
      lo_s_r    <= {lo_s_r[SYNC_LEN-2:0], low_byte_strobe_i};
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end

  // (RULE_23) inactive reset word
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= `CTRL_RESET;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // (RULE_03) high byte first, kept for the next low byte
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_byte_r <= 8'h00;
      hi_seen_r <= 1'b0;
    end else if (ce_i) begin
      // A new high byte wins over a clear in the same cycle
      if (lo_fall) begin
        hi_seen_r <= 1'b0;
      end
      if (hi_fall) begin
        hi_byte_r <= bus_byte;
        hi_seen_r <= 1'b1;
      end
    end
  end

  // Word frozen when a read starts so both bytes belong together
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_word_r <= 16'h0000;
    end else if (ce_i) begin
      if (hi_rise) begin
        rd_word_r <= rd_word_nxt;
      end
    end
  end

  // (RULE_02) data location write
  // Pulses last one cycle
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_wdata_o         <= 16'h0000;
      sec_wr_o            <= 1'b0;
      addr_counter_load_o <= 1'b0;
      post_count_load_o   <= 1'b0;
      rate_latch_load_o   <= 1'b0;
      trig_level_load_o   <= 1'b0;
    end else if (ce_i) begin
      sec_wr_o            <= 1'b0;
      addr_counter_load_o <= 1'b0;
      post_count_load_o   <= 1'b0;
      rate_latch_load_o   <= 1'b0;
      trig_level_load_o   <= 1'b0;
      if (at_secondary && lo_fall && !rd_en) begin
        // (RULE_05) byte or word write
        sec_wdata_o <= merge_word(hi_seen_r, hi_byte_r, 8'h00, bus_byte);
        sec_wr_o    <= 1'b1;
        // (RULE_14) counter load gates
        // (RULE_22) load needs read clock
        addr_counter_load_o <= rd_clk & ~ctrl_r[`BIT_ADDRLD_N];
        post_count_load_o   <= rd_clk & ~ctrl_r[`BIT_POSTLD_N];
        // (RULE_18) rate latch load
        rate_latch_load_o   <= ~ctrl_r[`BIT_RATELD_N];
        // (RULE_20) trigger level load
        trig_level_load_o   <= ~ctrl_r[`BIT_LEVELD_N];
      end
    end
  end

  // (RULE_05) read completes on low byte
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_rd_o    <= 1'b0;
      addr_incr_o <= 1'b0;
    end else if (ce_i) begin
      sec_rd_o    <= 1'b0;
      addr_incr_o <= 1'b0;
      if (at_secondary && lo_fall && rd_en) begin
        sec_rd_o    <= 1'b1;
        // (RULE_15) post-increment on read
        addr_incr_o <= rd_clk & rd_mem;
      end
    end
  end

  // (RULE_16) drive only when enabled
  // (RULE_17) trigger latch read
  // High byte comes live from the source, low byte from the frozen word in word reads and live in byte reads
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else if (ce_i) begin
      data_oe_o <= at_secondary && rd_en && strobe_on;
      if (hi_rise) begin
        data_o <= rd_word_nxt[15:8];
      end else if (lo_rise && hi_seen_r) begin
        data_o <= rd_word_r[7:0];
      end else if (lo_rise) begin
        data_o <= rd_word_nxt[7:0];
      end
    end
  end

  // Mode outputs, one cycle behind the control word
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_run_o               <= 1'b0;
      trig_arm_o                  <= 1'b0;
      double_gain_select_o        <= 1'b0;
      video_trigger_edge_select_o <= 1'b0;
      video_trigger_active_o      <= 1'b0;
      memory_write_enable_o       <= 1'b0;
      sweep_strobe_release_o      <= 1'b0;
    end else if (ce_i) begin
      // (RULE_08) capture mode
      capture_run_o               <= ctrl_r[`BIT_CAPTURE];
      // (RULE_09) trigger arming
      trig_arm_o                  <= ctrl_r[`BIT_ARM];
      // (RULE_10) amplifier control
      double_gain_select_o        <= ctrl_r[`BIT_GAIN2];
      // (RULE_11) video trigger
      video_trigger_edge_select_o <= ctrl_r[`BIT_VEDGE];
      video_trigger_active_o      <= ~ctrl_r[`BIT_VTRIG_N];
      // (RULE_13) memory write enable
      memory_write_enable_o       <= ~ctrl_r[`BIT_MEMWR_N];
      // (RULE_19) sweep release
      sweep_strobe_release_o      <= ~ctrl_r[`BIT_SWPREL_N];
    end
  end

  // Detection outputs; at most one is high
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_detect_o     <= 1'b0;
      min_detect_select_o <= 1'b0;
      peak_detect_o       <= 1'b0;
    end else if (ce_i) begin
      // (RULE_12) detection mode
      sample_detect_o     <= ~ctrl_r[`BIT_SAMPLE_N];
      // (RULE_21) peak or pit
      min_detect_select_o <= ctrl_r[`BIT_SAMPLE_N] & ctrl_r[`BIT_MINDET];
      peak_detect_o       <= ctrl_r[`BIT_SAMPLE_N] & ~ctrl_r[`BIT_MINDET];
    end
  end

endmodule
`default_nettype wire

// *** testbench/adc_port_properties.sv ***
// Checker of host port pulses and control outputs
`timescale 1ns/1ps
`default_nettype none
module adc_port_props (
  input wire logic clk_sys_i, nrst_i, location_select_line_i, high_byte_strobe_i,
  input wire logic low_byte_strobe_i, sec_wr_o, sec_rd_o, addr_counter_load_o,
  input wire logic post_count_load_o, rate_latch_load_o, trig_level_load_o, addr_incr_o,
  input wire logic capture_run_o, sample_detect_o, min_detect_select_o, peak_detect_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence quiet_bus;
    (!high_byte_strobe_i && !low_byte_strobe_i) [*6];
  endsequence
  wr_place_a: assert property (sec_wr_o |-> location_select_line_i && !low_byte_strobe_i)
    else $error("write off data place");
  wr_pulse_a: assert property (sec_wr_o |=> !sec_wr_o)
    else $error("write pulse too long");
  addr_load_a: assert property (addr_counter_load_o |-> sec_wr_o)
    else $error("stray address load");
  post_load_a: assert property (post_count_load_o |-> sec_wr_o)
    else $error("stray post load");
  rate_load_a: assert property (rate_latch_load_o |-> sec_wr_o)
    else $error("stray rate load");
  level_load_a: assert property (trig_level_load_o |-> sec_wr_o)
    else $error("stray level load");
  incr_read_a: assert property (addr_incr_o |-> sec_rd_o && !capture_run_o)
    else $error("bad increment");
  detect_one_a: assert property ($onehot0({sample_detect_o, min_detect_select_o, peak_detect_o}))
    else $error("two detect modes");
  ctrl_hold_a: assert property ($changed(capture_run_o) |-> !location_select_line_i)
    else $error("mode moved off control place");
  quiet_a: assert property (quiet_bus |-> !sec_wr_o && !sec_rd_o)
    else $error("pulse without strobe");
endmodule
bind fast_adc_host_control_port adc_port_props i_props (.*);
`default_nettype wire

// *** testbench/host_cpu_model.sv ***
// Host controller model on the byte-wide port
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic       clk_sys_i, // System clock
  input  wire logic       doe_i,     // Device drive enable
  input  wire logic [7:0] dout_i,    // Device read byte
  output logic            sel_o,     // Location select
  output logic            hs_o,      // High byte strobe
  output logic            ls_o,      // Low byte strobe
  output logic      [7:0] bus_o      // Bus level
);
  logic [7:0] hd = 0, last = 0;
  logic hen = 0;
  initial {sel_o, hs_o, ls_o} = 3'h0;
  // bus level, floats to changing pattern
  assign bus_o = doe_i ? dout_i : hen ? hd : ~last;
  always @(posedge clk_sys_i) last <= bus_o;
  task automatic byte_cyc(input logic hi, sel, wr, input logic [7:0] b, output logic [7:0] q);
    @(posedge clk_sys_i);
    sel_o <= sel;
    hd <= b;
    // host drives only on its writes
    hen <= wr;
    if (hi) hs_o <= 1; else ls_o <= 1;
    repeat (6) @(posedge clk_sys_i);
    q = bus_o;
    hs_o <= 0;
    ls_o <= 0;
    repeat (8) @(posedge clk_sys_i);
    hen <= 0;
  endtask
  task automatic xfer(input logic sel, two, wr, input logic [15:0] w, output logic [15:0] q);
    q = 0;
    if (two) byte_cyc(1, sel, wr, w[15:8], q[15:8]);
    byte_cyc(0, sel, wr, w[7:0], q[7:0]);
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the host control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 0, nrst_i = 0, ce_i = 1, sel, hs, ls, doe, wr, rd, inc;
  logic [7:0] din, dout;
  logic [15:0] mem_w = 16'hBEEF, trg_w = 16'h1234, wd, wdat, r;
  logic [3:0] ld, ldc;
  logic [9:0] lv;
  int fails = 0, cmp_count = 0, wr_cnt = 0, inc_cnt = 0, cyc = 0, rd_cnt = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  fast_adc_host_control_port i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .location_select_line_i(sel), .high_byte_strobe_i(hs), .low_byte_strobe_i(ls),
    .data_i(din), .data_o(dout), .data_oe_o(doe), .mem_word_i(mem_w), .trig_addr_i(trg_w),
    .sec_wdata_o(wdat), .sec_wr_o(wr), .sec_rd_o(rd), .addr_counter_load_o(ld[3]),
    .post_count_load_o(ld[2]), .rate_latch_load_o(ld[1]), .trig_level_load_o(ld[0]),
    .addr_incr_o(inc), .capture_run_o(lv[9]), .trig_arm_o(lv[8]),
    .double_gain_select_o(lv[7]), .video_trigger_edge_select_o(lv[6]),
    .video_trigger_active_o(lv[5]), .sample_detect_o(lv[4]), .min_detect_select_o(lv[3]),
    .peak_detect_o(lv[2]), .memory_write_enable_o(lv[1]), .sweep_strobe_release_o(lv[0]));
  host_cpu_model i_host (.clk_sys_i(clk_sys_i), .doe_i(doe), .dout_i(dout), .sel_o(sel),
    .hs_o(hs), .ls_o(ls), .bus_o(din));
  function automatic logic [9:0] lvx(input logic [15:0] c);
    return {c[0], c[1], c[2], c[3], ~c[8], ~c[4], c[4] & c[15], c[4] & ~c[15], ~c[5], ~c[13]};
  endfunction
  always @(posedge clk_sys_i) begin
    if (wr === 1'b1) begin
      wd <= wdat;
      ldc <= ld;
      wr_cnt <= wr_cnt + 1;
    end
    if (inc === 1'b1) inc_cnt <= inc_cnt + 1;
    if (rd === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task cw(input logic [15:0] c);
    i_host.xfer(0, 1, 1, c, r);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task t_ctrl;
    for (int i = 0; i < 16; i++) begin
      cw(16'h7FF0 ^ (16'h0001 << i));
      chk(lv, lvx(16'h7FF0 ^ (16'h0001 << i)));
    end
    i_host.xfer(0, 0, 1, 16'h000F, r);
    repeat (4) @(posedge clk_sys_i);
    chk(lv, lvx(16'hFF0F));
    ce_i <= 0;
    i_host.xfer(0, 1, 1, 16'h7FF1, r);
    ce_i <= 1;
    repeat (4) @(posedge clk_sys_i);
    chk(lv, lvx(16'hFF0F));
  endtask
  task t_write;
    cw(16'h2D30);
    i_host.xfer(1, 1, 1, 16'hA55A, r);
    chk({wd, ldc}, {16'hA55A, 4'hF});
    cw(16'h7FF0);
    i_host.xfer(1, 0, 1, 16'h003C, r);
    chk({wd, ldc}, {16'h003C, 4'h0});
  endtask
  task t_read;
    int n;
    cw(16'h79F0);
    n = inc_cnt;
    wd = rd_cnt;
    i_host.xfer(1, 1, 0, 16'h0000, r);
    chk(r, 16'hBEEF);
    chk(inc_cnt, n + 1);
    chk(rd_cnt, wd + 1);
    chk(doe, 1'b0);
    n = wr_cnt;
    i_host.xfer(1, 1, 1, 16'h1111, r);
    chk(wr_cnt, n);
    cw(16'h77F0);
    i_host.xfer(1, 1, 0, 16'h0000, r);
    chk(r, 16'h1234);
    cw(16'h79D1);
    n = inc_cnt;
    i_host.xfer(1, 1, 0, 16'h0000, r);
    chk(inc_cnt, n);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1;
    repeat (4) @(posedge clk_sys_i);
    chk(lv, lvx(16'h7FF0));
    t_ctrl();
    t_write();
    t_read();
    report_and_stop();
  end
endmodule
`default_nettype wire
